// >>> core/printer_port_pkg.sv
// ----------------------------------------------------------------------------
// shared constants and types of the printer port control and status pins
// ----------------------------------------------------------------------------
package printer_port_pkg;

   // ----------------------------------------------------------------------------
   // register bus geometry
   // ----------------------------------------------------------------------------
   localparam int ADDR_W = 2;
   localparam int DATA_W = 8;

   // ----------------------------------------------------------------------------
   // register offsets
   // ----------------------------------------------------------------------------
   localparam logic [ADDR_W-1:0] STATUS_OFFSET = 2'h0;
   localparam logic [ADDR_W-1:0] CONTROL_OFFSET = 2'h1;
   localparam logic [ADDR_W-1:0] CONFIG_OFFSET = 2'h2;

   // ----------------------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------------------
   localparam int STAT_FAULT_BIT = 3;
   localparam int CTRL_STROBE_BIT = 0;
   localparam int CTRL_LINEFEED_BIT = 1;
   localparam int CTRL_INIT_BIT = 2;
   localparam int CTRL_SELECT_BIT = 3;
   localparam int CFG_OPEN_DRAIN_BIT = 0;

   // ----------------------------------------------------------------------------
   // reset values and implemented-bit masks
   // ----------------------------------------------------------------------------
   localparam logic [DATA_W-1:0] CONTROL_RESET = 8'h00;
   localparam logic [DATA_W-1:0] CONFIG_RESET = 8'h00;
   localparam logic [DATA_W-1:0] CONTROL_MASK = 8'h0F;
   localparam logic [DATA_W-1:0] CONFIG_MASK = 8'h01;
   localparam logic [DATA_W-1:0] READ_IDLE = 8'h00;
   localparam logic FAULT_RESET_LEVEL = 1'b1;

   // ----------------------------------------------------------------------------
   // carriers
   // ----------------------------------------------------------------------------
   typedef struct packed {
      logic wr;
      logic rd;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } bus_req_t;

   typedef struct packed {
      logic out;
      logic oe;
   } pin_drive_t;

endpackage : printer_port_pkg

// >>> core/pin_sync.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------------------
// two-flop synchroniser for asynchronous pin inputs
// ----------------------------------------------------------------------------
module pin_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic reset_i,
   input wire logic clk_en_i,
   // pin side
   input wire logic [WIDTH-1:0] async_i,
   // synchronous side
   output logic [WIDTH-1:0] sync_o
);

   logic [WIDTH-1:0] meta_reg;
   logic [WIDTH-1:0] meta_next;
   logic [WIDTH-1:0] stable_reg;
   logic [WIDTH-1:0] stable_next;

   // first stage feeds only the second stage, never any logic
   always_comb begin
      meta_next = meta_reg;
      stable_next = stable_reg;
      if (clk_en_i) begin
         meta_next = async_i;
         stable_next = meta_reg;
      end
   end

   // registers only
   always_ff @(posedge clk_sys_i or posedge reset_i) begin
      if (reset_i) begin
         meta_reg <= RESET_VAL;
         stable_reg <= RESET_VAL;
      end else begin
         meta_reg <= meta_next;
         stable_reg <= stable_next;
      end
   end

   assign sync_o = stable_reg;

endmodule : pin_sync

// >>> core/pin_driver.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------------------
// output pin driver, push-pull or open-drain
// ----------------------------------------------------------------------------
module pin_driver (
   // wanted pin level
   input wire logic level_i,
   // drive style
   input wire logic open_drain_i,
   // pad controls
   output printer_port_pkg::pin_drive_t drive_o
);

   // open-drain only pulls low; a high level is left to the board pull-up
   always_comb begin
      if (open_drain_i) begin
         drive_o.out = 1'b0;
         drive_o.oe = ~level_i;
      end else begin
         drive_o.out = level_i;
         drive_o.oe = 1'b1;
      end
   end

endmodule : pin_driver

// >>> core/printer_port_ctrl.sv
`timescale 1ns/100ps
// Functional notes
// RULE_01: status bit 3 reads the printer fault input level, low means error.
// RULE_02: printer drives fault input low on error, high otherwise.
// RULE_03: select output, active low, is always the inverse of control bit 3.
// RULE_04: initialise output follows control bit 2 directly, not inverted.
// RULE_05: printer initialises while the initialise line is held low.
// RULE_06: auto line feed output, active low, is inverse of control bit 1.
// RULE_07: printer feeds a line after each line while line feed is low.
// RULE_08: strobe output, active low, is inverse of control bit 0.
// RULE_09: printer captures port data on a low strobe pulse.
module printer_port_ctrl (
   // clock, reset and enable
   input wire logic clk_sys_i,
   input wire logic reset_i,
   input wire logic clk_en_i,
   // register port
   input wire logic [printer_port_pkg::ADDR_W-1:0] addr_i,
   input wire logic [printer_port_pkg::DATA_W-1:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [printer_port_pkg::DATA_W-1:0] rdata_o,
   // printer status pin
   input wire logic printer_fault_in_i,
   // printer control pins
   output logic printer_select_out_o,
   output logic printer_select_out_oe_o,
   output logic printer_init_out_o,
   output logic printer_init_out_oe_o,
   output logic auto_linefeed_out_o,
   output logic auto_linefeed_out_oe_o,
   output logic data_strobe_out_o,
   output logic data_strobe_out_oe_o
);

   // ----------------------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------------------
   printer_port_pkg::bus_req_t req;
   logic [printer_port_pkg::DATA_W-1:0] control_reg;
   logic [printer_port_pkg::DATA_W-1:0] control_next;
   logic [printer_port_pkg::DATA_W-1:0] config_reg;
   logic [printer_port_pkg::DATA_W-1:0] config_next;
   logic [printer_port_pkg::DATA_W-1:0] rdata_reg;
   logic [printer_port_pkg::DATA_W-1:0] rdata_next;
   logic [printer_port_pkg::DATA_W-1:0] status_word;
   logic printer_fault_level;
   logic open_drain;
   logic select_level;
   logic init_level;
   logic linefeed_level;
   logic strobe_level;
   printer_port_pkg::pin_drive_t select_drive;
   printer_port_pkg::pin_drive_t init_drive;
   printer_port_pkg::pin_drive_t linefeed_drive;
   printer_port_pkg::pin_drive_t strobe_drive;

   // ----------------------------------------------------------------------------
   // request bundle
   // ----------------------------------------------------------------------------
   // the bus fields travel together so decode reads one carrier
   assign req.wr = wr_i;
   assign req.rd = rd_i;
   assign req.addr = addr_i;
   assign req.wdata = wdata_i;

   // ----------------------------------------------------------------------------
   // fault input synchroniser
   // ----------------------------------------------------------------------------
   // the printer is asynchronous to us; reset level means no error
   pin_sync #(
      .WIDTH(1),
      .RESET_VAL(printer_port_pkg::FAULT_RESET_LEVEL)
   ) u_fault_sync (
      .clk_sys_i(clk_sys_i),
      .reset_i(reset_i),
      .clk_en_i(clk_en_i),
      .async_i(printer_fault_in_i),
      .sync_o(printer_fault_level)
   );

   // ----------------------------------------------------------------------------
   // status word
   // ----------------------------------------------------------------------------
   // fault bit is the synchronised pin level, not inverted, so error reads as zero
   always_comb begin
      status_word = printer_port_pkg::READ_IDLE;
      status_word[printer_port_pkg::STAT_FAULT_BIT] = printer_fault_level; // see RULE_01
   end

   // ----------------------------------------------------------------------------
   // register writes
   // ----------------------------------------------------------------------------
   // unimplemented bits are masked on write so they always read zero;
   // writes to the status offset are dropped, it has no storage
   always_comb begin
      control_next = control_reg;
      config_next = config_reg;
      if (clk_en_i && req.wr) begin
         case (req.addr)
            printer_port_pkg::CONTROL_OFFSET: begin
               control_next = req.wdata & printer_port_pkg::CONTROL_MASK;
            end
            printer_port_pkg::CONFIG_OFFSET: begin
               config_next = req.wdata & printer_port_pkg::CONFIG_MASK;
            end
            default: begin
               control_next = control_reg;
               config_next = config_reg;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------------------
   // register reads
   // ----------------------------------------------------------------------------
   // read data stand for one enabled cycle only; enabled idle cycles return zero, a low enable holds them, so a
   // stale value is never mistaken for a fresh answer
   always_comb begin
      rdata_next = rdata_reg;
      if (clk_en_i) begin
         rdata_next = printer_port_pkg::READ_IDLE;
         if (req.rd) begin
            case (req.addr)
               printer_port_pkg::STATUS_OFFSET: begin
                  rdata_next = status_word; // see RULE_01
               end
               printer_port_pkg::CONTROL_OFFSET: begin
                  rdata_next = control_reg;
               end
               printer_port_pkg::CONFIG_OFFSET: begin
                  rdata_next = config_reg;
               end
               default: begin
                  rdata_next = printer_port_pkg::READ_IDLE;
               end
            endcase
         end
      end
   end

   // ----------------------------------------------------------------------------
   // register state
   // ----------------------------------------------------------------------------
   always_ff @(posedge clk_sys_i or posedge reset_i) begin
      if (reset_i) begin
         control_reg <= printer_port_pkg::CONTROL_RESET;
         config_reg <= printer_port_pkg::CONFIG_RESET;
         rdata_reg <= printer_port_pkg::READ_IDLE;
      end else begin
         control_reg <= control_next;
         config_reg <= config_next;
         rdata_reg <= rdata_next;
      end
   end

   assign rdata_o = rdata_reg;

   // ----------------------------------------------------------------------------
   // pin levels
   // ----------------------------------------------------------------------------
   // levels come straight off the control flops, so a write shows on the
   // pins at the edge that stores it; strobe width is set by software
   assign select_level = ~control_reg[printer_port_pkg::CTRL_SELECT_BIT]; // see RULE_03
   assign init_level = control_reg[printer_port_pkg::CTRL_INIT_BIT]; // see RULE_04
   assign linefeed_level = ~control_reg[printer_port_pkg::CTRL_LINEFEED_BIT]; // see RULE_06
   assign strobe_level = ~control_reg[printer_port_pkg::CTRL_STROBE_BIT]; // see RULE_08
   assign open_drain = config_reg[printer_port_pkg::CFG_OPEN_DRAIN_BIT];

   // ----------------------------------------------------------------------------
   // pin drivers
   // ----------------------------------------------------------------------------
   pin_driver u_select_drv (
      .level_i(select_level),
      .open_drain_i(open_drain),
      .drive_o(select_drive)
   );

   pin_driver u_init_drv (
      .level_i(init_level),
      .open_drain_i(open_drain),
      .drive_o(init_drive)
   );

   pin_driver u_linefeed_drv (
      .level_i(linefeed_level),
      .open_drain_i(open_drain),
      .drive_o(linefeed_drive)
   );

   pin_driver u_strobe_drv (
      .level_i(strobe_level),
      .open_drain_i(open_drain),
      .drive_o(strobe_drive)
   );

   // pad outputs
   assign printer_select_out_o = select_drive.out;
   assign printer_select_out_oe_o = select_drive.oe;
   assign printer_init_out_o = init_drive.out;
   assign printer_init_out_oe_o = init_drive.oe;
   assign auto_linefeed_out_o = linefeed_drive.out;
   assign auto_linefeed_out_oe_o = linefeed_drive.oe;
   assign data_strobe_out_o = strobe_drive.out;
   assign data_strobe_out_oe_o = strobe_drive.oe;

   // ----------------------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------------------
   // wire level as the board sees it, undriven pins float high
   logic select_wire;
   logic init_wire;
   logic linefeed_wire;
   logic strobe_wire;
   logic ctrl_write;
   assign select_wire = printer_select_out_oe_o ? printer_select_out_o : 1'b1;
   assign init_wire = printer_init_out_oe_o ? printer_init_out_o : 1'b1;
   assign linefeed_wire = auto_linefeed_out_oe_o ? auto_linefeed_out_o : 1'b1;
   assign strobe_wire = data_strobe_out_oe_o ? data_strobe_out_o : 1'b1;
   assign ctrl_write = clk_en_i && wr_i && (addr_i == printer_port_pkg::CONTROL_OFFSET);

   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (reset_i);

   a_fault_to_level: assert property ( // see RULE_01
      (clk_en_i && $stable(printer_fault_in_i))[*3] |-> printer_fault_level == printer_fault_in_i)
      else $error("fault level did not follow the fault pin");

   a_fault_status_read: assert property ( // see RULE_01
      (clk_en_i && rd_i && addr_i == printer_port_pkg::STATUS_OFFSET)
      |=> rdata_o[printer_port_pkg::STAT_FAULT_BIT] == $past(printer_fault_level))
      else $error("status read did not return the fault level");

   a_select_inverts: assert property ( // see RULE_03
      ctrl_write |=> select_wire == ~$past(wdata_i[printer_port_pkg::CTRL_SELECT_BIT]))
      else $error("select pin is not the inverse of its control bit");

   a_init_follows: assert property ( // see RULE_04
      ctrl_write |=> init_wire == $past(wdata_i[printer_port_pkg::CTRL_INIT_BIT]))
      else $error("init pin does not follow its control bit");

   a_linefeed_inverts: assert property ( // see RULE_06
      ctrl_write |=> linefeed_wire == ~$past(wdata_i[printer_port_pkg::CTRL_LINEFEED_BIT]))
      else $error("line feed pin is not the inverse of its control bit");

   a_strobe_inverts: assert property ( // see RULE_08
      ctrl_write |=> strobe_wire == ~$past(wdata_i[printer_port_pkg::CTRL_STROBE_BIT]))
      else $error("strobe pin is not the inverse of its control bit");

   a_strobe_holds: assert property ( // see RULE_08
      !ctrl_write |=> $stable(strobe_wire))
      else $error("strobe pin moved without a control write");

   a_open_drain_low: assert property (
      open_drain |-> !(data_strobe_out_o || printer_select_out_o || printer_init_out_o
                       || auto_linefeed_out_o))
      else $error("open-drain pin driven high");

   a_read_one_cycle: assert property (
      (clk_en_i && !rd_i) |=> rdata_o == printer_port_pkg::READ_IDLE)
      else $error("read data stood beyond the answer cycle");

   // pins must match the stored bits at every edge, not only after a write
   a_select_tracks: assert property ( // see RULE_03
      select_wire == ~control_reg[printer_port_pkg::CTRL_SELECT_BIT])
      else $error("select pin differs from its stored control bit");

   a_init_tracks: assert property ( // see RULE_04
      init_wire == control_reg[printer_port_pkg::CTRL_INIT_BIT])
      else $error("init pin differs from its stored control bit");

   a_linefeed_tracks: assert property ( // see RULE_06
      linefeed_wire == ~control_reg[printer_port_pkg::CTRL_LINEFEED_BIT])
      else $error("line feed pin differs from its stored control bit");

   a_strobe_tracks: assert property ( // see RULE_08
      strobe_wire == ~control_reg[printer_port_pkg::CTRL_STROBE_BIT])
      else $error("strobe pin differs from its stored control bit");

   // push-pull drives every pin at all times, so no pin is left to float
   a_push_pull_oe: assert property (
      !open_drain |-> (printer_select_out_oe_o && printer_init_out_oe_o
                       && auto_linefeed_out_oe_o && data_strobe_out_oe_o))
      else $error("push-pull pin left undriven");

   // a low enable freezes every register, the read data included
   a_enable_freeze: assert property (
      !clk_en_i |=> ($stable(control_reg) && $stable(config_reg) && $stable(rdata_o)))
      else $error("state moved while the clock enable was low");

   c_strobe_pulse: cover property (
      strobe_wire ##1 !strobe_wire [*2] ##1 strobe_wire);
   c_fault_read_low: cover property (
      (rd_i && clk_en_i && addr_i == printer_port_pkg::STATUS_OFFSET && !printer_fault_level)
      ##1 !rdata_o[printer_port_pkg::STAT_FAULT_BIT]);
   c_open_drain_pulse: cover property (
      open_drain && ctrl_write ##1 !strobe_wire);
   c_init_pulse: cover property (
      !init_wire ##1 init_wire);

endmodule : printer_port_ctrl

// >>> testbench/printer_model.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------------------
// printer attached to the port, behavioural
// ----------------------------------------------------------------------------
module printer_model (
   // fault request from the test
   input wire logic error_i,
   // wire levels seen at the printer connector
   input wire logic select_wire_i,
   input wire logic init_wire_i,
   input wire logic linefeed_wire_i,
   input wire logic strobe_wire_i,
   // printer state as seen by the test
   output logic printer_fault_in_o,
   output logic in_init_o,
   output logic selected_o,
   output logic auto_feed_o,
   output int captures_o
);
   // fault line low only while an error stands; a short delay, like a real driver
   assign #2 printer_fault_in_o = ~error_i;
   // printer sits in initialisation for as long as the line is low
   assign in_init_o = (init_wire_i === 1'b0);
   assign selected_o = (select_wire_i === 1'b0);
   // automatic line feed mode while the line is low
   assign auto_feed_o = (linefeed_wire_i === 1'b0);
   // data latched as the strobe returns high; a printer in init ignores it
   initial captures_o = 0;
   always @(posedge strobe_wire_i) begin
      if (!in_init_o) captures_o = captures_o + 1;
   end
endmodule : printer_model

// >>> testbench/printer_port_control_status_pins_tb.sv
`timescale 1ns/100ps
module printer_port_control_status_pins_tb;
   // ----------------------------------------------------------------------------
   // signals
   // ----------------------------------------------------------------------------
   logic clk_sys_i, reset_i, clk_en_i, wr_i, rd_i, error_req;
   logic [1:0] addr_i;
   logic [7:0] wdata_i, rdata_o, d;
   logic [3:0] oe_exp;
   logic fault_pin, in_init, selected, auto_feed;
   logic sel_o, sel_oe, ini_o, ini_oe, lf_o, lf_oe, stb_o, stb_oe;
   logic sel_w, ini_w, lf_w, stb_w;
   int captures, c0, bad_count, n_tests;
   // wire levels: pull-up when a pin is not driven
   assign sel_w = sel_oe ? sel_o : 1'b1;
   assign ini_w = ini_oe ? ini_o : 1'b1;
   assign lf_w = lf_oe ? lf_o : 1'b1;
   assign stb_w = stb_oe ? stb_o : 1'b1;

   printer_port_ctrl dut (
      .clk_sys_i(clk_sys_i), .reset_i(reset_i), .clk_en_i(clk_en_i),
      .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
      .printer_fault_in_i(fault_pin),
      .printer_select_out_o(sel_o), .printer_select_out_oe_o(sel_oe),
      .printer_init_out_o(ini_o), .printer_init_out_oe_o(ini_oe),
      .auto_linefeed_out_o(lf_o), .auto_linefeed_out_oe_o(lf_oe),
      .data_strobe_out_o(stb_o), .data_strobe_out_oe_o(stb_oe)
   );

   printer_model printer (
      .error_i(error_req), .select_wire_i(sel_w), .init_wire_i(ini_w),
      .linefeed_wire_i(lf_w), .strobe_wire_i(stb_w), .printer_fault_in_o(fault_pin),
      .in_init_o(in_init), .selected_o(selected), .auto_feed_o(auto_feed),
      .captures_o(captures)
   );

   // ----------------------------------------------------------------------------
   // clock and watchdog
   // ----------------------------------------------------------------------------
   initial begin
      clk_sys_i = 1'b0;
      forever #5 clk_sys_i = ~clk_sys_i;
   end
   // the tests need some 175 cycles; some fourteen times that (2500 cycles) means a hang
   initial begin
      #25000;
      bad_count++;
      print_verdict();
   end

   // ----------------------------------------------------------------------------
   // access tasks
   // ----------------------------------------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         bad_count++;
         $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask : check
   task automatic write_reg(input logic [1:0] a, input logic [7:0] v);
      @(posedge clk_sys_i);
      wr_i <= 1'b1;
      addr_i <= a;
      wdata_i <= v;
      @(posedge clk_sys_i);
      wr_i <= 1'b0;
      #1;
   endtask : write_reg
   // data stand only in the cycle after the strobe, so sample there
   task automatic read_reg(input logic [1:0] a, output logic [7:0] v);
      @(posedge clk_sys_i);
      rd_i <= 1'b1;
      addr_i <= a;
      @(posedge clk_sys_i);
      rd_i <= 1'b0;
      #1 v = rdata_o;
   endtask : read_reg
   task automatic check_pins(input logic [3:0] v);
      check({sel_w, ini_w, lf_w, stb_w}, {~v[3], v[2], ~v[1], ~v[0]});
      check(in_init, !v[2]);
   endtask : check_pins
   task automatic print_verdict;
      $display("comparisons %0d, mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : print_verdict

   // ----------------------------------------------------------------------------
   // test sequence
   // ----------------------------------------------------------------------------
   initial begin
      bad_count = 0;
      n_tests = 0;
      reset_i = 1'b1;
      clk_en_i = 1'b1;
      wr_i = 1'b0;
      rd_i = 1'b0;
      addr_i = 2'h0;
      wdata_i = 8'h00;
      error_req = 1'b0;
      repeat (8) @(posedge clk_sys_i);
      reset_i <= 1'b0;
      #1 check_pins(4'h0);
      read_reg(printer_port_pkg::CONTROL_OFFSET, d);
      check(d, 8'h00);
      // every control pattern, push-pull and open-drain; upper bits must not stick
      for (int m = 0; m < 2; m++) begin
         write_reg(printer_port_pkg::CONFIG_OFFSET, {7'h7F, m[0]});
         read_reg(printer_port_pkg::CONFIG_OFFSET, d);
         check(d, {7'h00, m[0]});
         for (int v = 0; v < 16; v++) begin
            write_reg(printer_port_pkg::CONTROL_OFFSET, {4'hA, v[3:0]});
            check_pins(v[3:0]);
            // open-drain releases a pin whose level is high
            oe_exp = m[0] ? {v[3], ~v[2], v[1], v[0]} : 4'hF;
            check({sel_oe, ini_oe, lf_oe, stb_oe}, oe_exp);
            check({selected, auto_feed}, {v[3], v[1]});
            read_reg(printer_port_pkg::CONTROL_OFFSET, d);
            check(d, {4'h0, v[3:0]});
         end
      end
      // strobe pulse made by setting and clearing bit 0
      write_reg(printer_port_pkg::CONFIG_OFFSET, 8'h00);
      write_reg(printer_port_pkg::CONTROL_OFFSET, 8'h04);
      c0 = captures;
      write_reg(printer_port_pkg::CONTROL_OFFSET, 8'h05);
      check(stb_w, 1'b0);
      write_reg(printer_port_pkg::CONTROL_OFFSET, 8'h04);
      check(captures, c0 + 1);
      // fault input reaches status bit 3 after synchronisation
      error_req <= 1'b1;
      repeat (3) @(posedge clk_sys_i);
      read_reg(printer_port_pkg::STATUS_OFFSET, d);
      check(d, 8'h00);
      error_req <= 1'b0;
      repeat (3) @(posedge clk_sys_i);
      read_reg(printer_port_pkg::STATUS_OFFSET, d);
      check(d, 8'h08);
      // read data stand one cycle only, then fall back to idle
      @(posedge clk_sys_i);
      #1 check(rdata_o, 8'h00);
      // unmapped address and read-only status
      write_reg(2'h3, 8'hFF);
      read_reg(2'h3, d);
      check(d, 8'h00);
      write_reg(printer_port_pkg::STATUS_OFFSET, 8'hFF);
      read_reg(printer_port_pkg::STATUS_OFFSET, d);
      check(d, 8'h08);
      // a write with the clock enable low is ignored
      @(posedge clk_sys_i);
      clk_en_i <= 1'b0;
      wr_i <= 1'b1;
      addr_i <= printer_port_pkg::CONTROL_OFFSET;
      wdata_i <= 8'h0B;
      @(posedge clk_sys_i);
      wr_i <= 1'b0;
      clk_en_i <= 1'b1;
      #1 check_pins(4'h4);
      print_verdict();
   end
endmodule : printer_port_control_status_pins_tb
